//--- rtl/dram_odt_control.sv
// on-die termination controller top with AXI4-Lite register slave
`timescale 1ns/10ps
`include "dram_odt_cfg.svh"
// Notes on behaviour
// - a new command/address termination value reaches the outputs four cycles after its write: a 20 ns (two cycle) delay plus two register stages.
// - data-group termination is forced off in power-down or self-refresh.
// - data-group termination opens only after a sampled write-first.
// - data-group mode is on when the low nibble is non-zero with bit 3 set, else off.
// - with the mode on, data pins stay high impedance outside the write window.
// - termination turns on by itself after a write, with no control pin.
// - termination turns off by itself when the burst's window ends.
// - turn-on starts a programmable latency after the second column command.
// - turn-off starts a programmable latency after the second column command.
// - turn-on settle is between its minimum and maximum after the on latency.
// - turn-off settle is between its minimum and maximum after the off latency.
// - command/address resistance comes from config bits 6 to 4.
// - command/address termination is off after reset until programmed.
// - data-group resistance comes from config bits 2 to 0.
module dram_odt_control
    import dram_odt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device events
    input  wire logic        write_first_i,
    input  wire logic        column2_i,
    input  wire logic        power_down_i,
    input  wire logic        self_refresh_i,
    // termination controls
    output logic             dq_term_en_o,
    output logic [2:0]       dq_term_code_o,
    output logic             dq_hiz_o,
    output logic             ca_term_en_o,
    output logic             ck_term_en_o,
    output logic             cs_term_en_o,
    output logic [2:0]       ca_term_code_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0]  config_val;
        logic [7:0]  override_val;
        logic [7:0]  lat_on;
        logic [7:0]  lat_off;
        logic        cfg_wr;
        logic        aw_got;
        logic [11:0] aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        wr_pend;
        logic        dq_en;
        logic [2:0]  dq_code;
        logic        dq_hiz;
        logic        ca_en;
        logic        ck_en;
        logic        cs_en;
        logic [2:0]  ca_code;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;

    term_cfg_if cfg ();

    logic seq_on;
    logic seq_busy;
    logic mode_en;
    logic low_power;

    // low nibble non-zero, but bit 3 clear still means off
    assign mode_en   = st_q.config_val[`DQ_TERM_MODE_MSB];
    assign low_power = power_down_i || self_refresh_i;

    assign cfg.config_val   = st_q.config_val;
    assign cfg.override_val = st_q.override_val;
    assign cfg.config_wr    = st_q.cfg_wr;

    ca_term_update u_ca
    (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .cfg      (cfg.ca)
    );

    // write-first held until column 2
    dq_term_seq u_dq
    (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .write_start_i (column2_i && (st_q.wr_pend || write_first_i)),
        .mode_en_i     (mode_en),
        .low_power_i   (low_power),
        .lat_on_i      (st_q.lat_on),
        .lat_off_i     (st_q.lat_off),
        .term_on_o     (seq_on),
        .busy_o        (seq_busy)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic        do_wr;
        logic [11:0] rd_addr;
        do_wr   = 1'b0;
        rd_addr = s_axi_araddr;
        st_d        = st_q;
        st_d.cfg_wr = 1'b0;

        if (write_first_i && mode_en && !low_power)
        begin
            st_d.wr_pend = 1'b1;
        end
        if (column2_i || low_power)
        begin
            st_d.wr_pend = 1'b0;
        end

        if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid)
        begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid)
        begin
            st_d.w_got  = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        do_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid;
        if (do_wr)
        begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = 2'b00;
            case (st_q.aw_addr)
                `TERM_CONFIG_OFFS:
                begin
                    if (st_q.w_strb[0])
                    begin
                        st_d.config_val = {1'b0, st_q.w_data[6:0]};
                        st_d.cfg_wr     = 1'b1;
                    end
                end
                `TERM_OVERRIDE_OFFS:
                begin
                    if (st_q.w_strb[0])
                    begin
                        st_d.override_val = {2'b00, st_q.w_data[5:0]};
                    end
                end
                `LATENCY_OFFS:
                begin
                    if (st_q.w_strb[0])
                    begin
                        st_d.lat_on = st_q.w_data[`LAT_ON_LSB +: 8];
                    end
                    if (st_q.w_strb[1])
                    begin
                        st_d.lat_off = st_q.w_data[`LAT_OFF_LSB +: 8];
                    end
                end
                default:
                begin
                    st_d.bresp = 2'b10;
                end
            endcase
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
        end

        if (s_axi_arvalid && !st_q.rvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = 2'b00;
            case (rd_addr)
                `TERM_CONFIG_OFFS:   st_d.rdata = {24'h00_0000, st_q.config_val};
                `TERM_OVERRIDE_OFFS: st_d.rdata = {24'h00_0000, st_q.override_val};
                `LATENCY_OFFS:       st_d.rdata = {16'h0000, st_q.lat_off, st_q.lat_on};
                `STATUS_OFFS:
                begin
                    st_d.rdata = {22'h00_0000, cfg.ca_busy, seq_busy, st_q.ca_code,
                                  st_q.ca_en, st_q.ck_en, st_q.cs_en, st_q.dq_en, st_q.dq_hiz};
                end
                default:
                begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rresp = 2'b10;
                end
            endcase
        end
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
        end

        // settle windows are sub-cycle
        st_d.dq_en   = seq_on && mode_en && !low_power;
        st_d.dq_hiz  = !st_d.dq_en;
        st_d.dq_code = st_q.config_val[`DQ_TERM_CODE_MSB:0];
        st_d.ca_en   = cfg.ca_on;
        st_d.ck_en   = cfg.ck_on;
        st_d.cs_en   = cfg.cs_on;
        st_d.ca_code = cfg.ca_code;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q              <= '0;
            st_q.config_val   <= `TERM_CONFIG_RST;
            st_q.override_val <= `TERM_OVERRIDE_RST;
            st_q.lat_on       <= `LAT_ON_RST;
            st_q.lat_off      <= `LAT_OFF_RST;
            st_q.dq_hiz       <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready  = !st_q.aw_got && !st_q.bvalid;
    assign s_axi_wready   = !st_q.w_got && !st_q.bvalid;
    assign s_axi_bvalid   = st_q.bvalid;
    assign s_axi_bresp    = st_q.bresp;
    assign s_axi_arready  = !st_q.rvalid;
    assign s_axi_rvalid   = st_q.rvalid;
    assign s_axi_rdata    = st_q.rdata;
    assign s_axi_rresp    = st_q.rresp;
    assign dq_term_en_o   = st_q.dq_en;
    assign dq_term_code_o = st_q.dq_code;
    assign dq_hiz_o       = st_q.dq_hiz;
    assign ca_term_en_o   = st_q.ca_en;
    assign ck_term_en_o   = st_q.ck_en;
    assign cs_term_en_o   = st_q.cs_en;
    assign ca_term_code_o = st_q.ca_code;
endmodule // dram_odt_control

//--- rtl/dram_odt_cfg.svh
// constants of the on-die termination controller
`ifndef DRAM_ODT_CFG_SVH
`define DRAM_ODT_CFG_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TERM_CONFIG_OFFS      12'h02C
`define TERM_OVERRIDE_OFFS    12'h058
`define LATENCY_OFFS          12'h100
`define STATUS_OFFS           12'h104
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DQ_TERM_MODE_MSB      3
`define DQ_TERM_CODE_MSB      2
`define CA_TERM_CODE_LSB      4
`define CA_TERM_CODE_MSB      6
`define CLK_FORCE_OFF_BIT     3
`define SEL_FORCE_OFF_BIT     4
`define CA_DISABLE_BIT        5
`define LAT_ON_LSB            0
`define LAT_OFF_LSB           8
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TERM_CONFIG_RST       8'h00
`define TERM_OVERRIDE_RST     8'h00
`define LAT_ON_RST            8'h06
`define LAT_OFF_RST           8'h18
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS         10
`define CA_TERM_UPDATE_NS     20
`define CA_TERM_UPDATE_CYC    ((`CA_TERM_UPDATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TERM_ON_SETTLE_MIN_NS 2
`define TERM_ON_SETTLE_MAX_NS 3
`endif

//--- rtl/dram_odt_pkg.sv
// types of the on-die termination controller
package dram_odt_pkg;
    typedef enum logic [2:0]
    {
        TERM_OFF     = 3'b001,
        TERM_WAIT_ON = 3'b010,
        TERM_ON      = 3'b100
    } term_state_t;

    typedef enum logic [2:0]
    {
        OHM_NONE = 3'b000,
        OHM_240  = 3'b001,
        OHM_120  = 3'b010,
        OHM_80   = 3'b011,
        OHM_60   = 3'b100,
        OHM_48   = 3'b101,
        OHM_40   = 3'b110
    } term_code_t;
endpackage

//--- rtl/term_cfg_if.sv
// configuration carrier between the termination top and its command/address sub-block
`timescale 1ns/10ps
interface term_cfg_if;
    logic [7:0] config_val;
    logic [7:0] override_val;
    logic       config_wr;
    logic [2:0] ca_code;
    logic       ca_on;
    logic       ck_on;
    logic       cs_on;
    logic       ca_busy;
    modport ctrl (output config_val, output override_val, output config_wr,
                  input ca_code, input ca_on, input ck_on, input cs_on, input ca_busy);
    modport ca   (input config_val, input override_val, input config_wr,
                  output ca_code, output ca_on, output ck_on, output cs_on, output ca_busy);
endinterface

//--- rtl/ca_term_update.sv
// command/address termination value update with delayed apply
`timescale 1ns/10ps
`include "dram_odt_cfg.svh"
module ca_term_update
    import dram_odt_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    term_cfg_if.ca    cfg
);
    typedef struct packed
    {
        logic [2:0] code;
        logic [2:0] pend;
        logic [2:0] cnt;
        logic       busy;
    } ca_state_t;

    ca_state_t st_q;
    ca_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (cfg.config_wr)
        begin
            st_d.pend = cfg.config_val[`CA_TERM_CODE_MSB:`CA_TERM_CODE_LSB];
            st_d.cnt  = 3'(`CA_TERM_UPDATE_CYC);
            st_d.busy = 1'b1;
        end
        else if (st_q.busy)
        begin
            if (st_q.cnt <= 3'h1)
            begin
                st_d.code = st_q.pend;
                st_d.busy = 1'b0;
                st_d.cnt  = 3'h0;
            end
            else
            begin
                st_d.cnt = st_q.cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // unused code 111 counts as disabled
    logic valid_code;
    assign valid_code  = (st_q.code != OHM_NONE) && (st_q.code != 3'b111);
    assign cfg.ca_code = st_q.code;
    assign cfg.ca_on   = valid_code && !cfg.override_val[`CA_DISABLE_BIT];
    assign cfg.ck_on   = valid_code && !cfg.override_val[`CLK_FORCE_OFF_BIT];
    assign cfg.cs_on   = valid_code && !cfg.override_val[`SEL_FORCE_OFF_BIT];
    assign cfg.ca_busy = st_q.busy;
endmodule // ca_term_update

//--- rtl/dq_term_seq.sv
// data-group termination window sequencer
`timescale 1ns/10ps
`include "dram_odt_cfg.svh"
module dq_term_seq
    import dram_odt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       write_start_i,
    input  wire logic       mode_en_i,
    input  wire logic       low_power_i,
    input  wire logic [7:0] lat_on_i,
    input  wire logic [7:0] lat_off_i,
    output logic            term_on_o,
    output logic            busy_o
);
    typedef struct packed
    {
        term_state_t state;
        logic [7:0]  cnt;
    } seq_state_t;

    seq_state_t st_q;
    seq_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q.state)
            TERM_OFF:
            begin
                if (write_start_i && mode_en_i && !low_power_i)
                begin
                    st_d.cnt   = 8'h01;
                    st_d.state = TERM_WAIT_ON;
                end
            end
            TERM_WAIT_ON:
            begin
                st_d.cnt = st_q.cnt + 8'h01;
                if (st_q.cnt >= lat_on_i)
                begin
                    st_d.state = TERM_ON;
                end
            end
            TERM_ON:
            begin
                st_d.cnt = st_q.cnt + 8'h01;
                if (st_q.cnt >= lat_off_i)
                begin
                    st_d.state = TERM_OFF;
                    st_d.cnt   = 8'h00;
                end
            end
            default:
            begin
                st_d.state = TERM_OFF;
                st_d.cnt   = 8'h00;
            end
        endcase
        if (low_power_i || !mode_en_i)
        begin
            st_d.state = TERM_OFF;
            st_d.cnt   = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_q <= '{state: TERM_OFF, cnt: 8'h00};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign term_on_o = (st_q.state == TERM_ON);
    assign busy_o    = (st_q.state != TERM_OFF);
endmodule // dq_term_seq

//--- bench/dram_odt_control_props.sv
// port assertions of the termination controller
`timescale 1ns/10ps
`include "dram_odt_cfg.svh"
module dram_odt_control_props
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    input  wire logic        column2_i,
    input  wire logic        power_down_i,
    input  wire logic        self_refresh_i,
    input  wire logic        dq_term_en_o,
    input  wire logic [2:0]  dq_term_code_o,
    input  wire logic        dq_hiz_o,
    input  wire logic        ca_term_en_o,
    input  wire logic        ck_term_en_o,
    input  wire logic        cs_term_en_o,
    input  wire logic [2:0]  ca_term_code_o
);
    // --------------------
    // helper state
    // --------------------
    logic        b_q;
    logic [11:0] wa_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic [7:0]  cfg_q;
    logic [8:0]  since_c2_q;
    logic [8:0]  on_q;
    logic        cfg_hit;

    // config write at response rise
    assign cfg_hit = s_axi_bvalid && !b_q && s_axi_bresp == 2'h0 && ws_q[0]
                     && wa_q == `TERM_CONFIG_OFFS;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            b_q        <= 1'b0;
            wa_q       <= 12'h000;
            wd_q       <= 32'h0000_0000;
            ws_q       <= 4'h0;
            cfg_q      <= 8'h00;
            since_c2_q <= 9'h1ff;
            on_q       <= 9'h000;
        end
        else
        begin
            b_q <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
                wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready)
                {ws_q, wd_q} <= {s_axi_wstrb, s_axi_wdata};
            if (cfg_hit)
                cfg_q <= wd_q[7:0];
            // saturates: a late rise still fails
            if (column2_i)
                since_c2_q <= 9'h000;
            else if (since_c2_q != 9'h1ff)
                since_c2_q <= since_c2_q + 9'h001;
            on_q <= dq_term_en_o ? on_q + 9'h001 : 9'h000;
        end
    end

    // --------------------
    // assertions
    // --------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    hiz_inverse_a: assert property (dq_hiz_o == !dq_term_en_o)
        else $error("pins not hi-z");
    lowpwr_off_a: assert property ((power_down_i || self_refresh_i) [*3] |-> !dq_term_en_o)
        else $error("term on in low power");
    rise_cause_a: assert property ($rose(dq_term_en_o) |-> since_c2_q <= 9'h104)
        else $error("rise without write");
    window_len_a: assert property (on_q <= 9'h100)
        else $error("window not closed");
    dq_code_a: assert property (cfg_hit |-> ##[0:1] dq_term_code_o == wd_q[2:0])
        else $error("dq code wrong");
    ca_hold_a: assert property (s_axi_awvalid && s_axi_awready |=> $stable(ca_term_code_o) [*2])
        else $error("ca code early");
    ca_apply_a: assert property (cfg_hit && wd_q[6:4] inside {[3'h1:3'h6]}
                                 |-> ##[2:4] ca_term_code_o == cfg_q[6:4])
        else $error("ca code not applied");
    ca_en_a: assert property ((ca_term_en_o || ck_term_en_o || cs_term_en_o)
                              |-> ca_term_code_o inside {[3'h1:3'h6]})
        else $error("ca on, bad code");
    bresp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
                                   && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("bvalid late");
    rvalid_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("rvalid late");
endmodule // dram_odt_control_props

bind dram_odt_control dram_odt_control_props i_props (.*);

//--- bench/host_cmd_model.sv
// host model: write commands and power states
`timescale 1ns/10ps
module host_cmd_model
(
    input  wire logic clk_i,
    output logic      write_first_o,
    output logic      column2_o,
    output logic      power_down_o,
    output logic      self_refresh_o
);
    initial
    begin
        write_first_o  = 1'b0;
        column2_o      = 1'b0;
        power_down_o   = 1'b0;
        self_refresh_o = 1'b0;
    end

    // --------------------
    // write-1, then column 2 gap cycles later
    // --------------------
    task automatic send_write(input int gap);
        write_first_o <= 1'b1;
        repeat (gap)
        begin
            @(posedge clk_i);
            write_first_o <= 1'b0;
        end
        column2_o <= 1'b1;
        @(posedge clk_i);
        write_first_o <= 1'b0;
        column2_o     <= 1'b0;
    endtask

    task automatic set_power(input logic pd, input logic sr);
        power_down_o   <= pd;
        self_refresh_o <= sr;
    endtask
endmodule // host_cmd_model

//--- bench/dram_odt_control_tb.sv
// bench of the termination controller
`timescale 1ns/10ps
`include "dram_odt_cfg.svh"
module dram_odt_control_tb
    import dram_odt_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rnd;
    logic        write_first_i, column2_i, power_down_i, self_refresh_i, prev_on = 1'b0;
    logic        dq_term_en_o, dq_hiz_o, ca_term_en_o, ck_term_en_o, cs_term_en_o;
    logic [2:0]  dq_term_code_o, ca_term_code_o;
    logic [7:0]  lon, loff, ovr;
    int          n_mismatch = 0, n_tests = 0, cyc = 0, col2_at, on_at, off_at, n_on = 0, n0;
    integer      seed = 32'hb64d;

    always #5 clk_i = ~clk_i;

    dram_odt_control i_dut (.*);
    host_cmd_model i_host (.clk_i(clk_i), .write_first_o(write_first_i), .column2_o(column2_i),
                           .power_down_o(power_down_i), .self_refresh_o(self_refresh_i));

    // --------------------
    // checks
    // --------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // window monitor and hang limit
    always @(negedge clk_i)
    begin
        cyc++;
        if (column2_i)
            col2_at = cyc;
        if (dq_term_en_o && !prev_on)
            on_at = cyc;
        n_on += int'(dq_term_en_o && !prev_on);
        if (!dq_term_en_o && prev_on)
            off_at = cyc;
        prev_on = dq_term_en_o;
        if (cyc == 30000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // --------------------
    // bus master
    // --------------------
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
        logic aw_ok, w_ok, b_ok;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(negedge clk_i);
            aw_ok = s_axi_awready;
            w_ok  = s_axi_wready;
            b_ok  = s_axi_bvalid;
            rsp   = s_axi_bresp;
            @(posedge clk_i);
            if (aw_ok)
                s_axi_awvalid <= 1'b0;
            if (w_ok)
                s_axi_wvalid <= 1'b0;
        end
        while (!b_ok);
        s_axi_bready <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] d;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(negedge clk_i);
            ar_ok = s_axi_arready;
            r_ok  = s_axi_rvalid;
            d     = s_axi_rdata;
            rsp   = s_axi_rresp;
            @(posedge clk_i);
            if (ar_ok)
                s_axi_arvalid <= 1'b0;
        end
        while (!r_ok);
        s_axi_rready <= 1'b0;
        check("rdata", exp, d);
        check("rresp", er, rsp);
        @(posedge clk_i);
    endtask

    // expected {ca, ck, cs} enables
    function automatic logic [2:0] ca_exp(input logic [7:0] cfg, input logic [7:0] ov);
        logic v;
        v = cfg[6:4] inside {[3'h1:3'h6]};
        return {v & !ov[5], v & !ov[3], v & !ov[4]};
    endfunction

    // --------------------
    // scenarios
    // --------------------
    initial
    begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rd_chk(`TERM_CONFIG_OFFS, 32'h0000_0000, 2'h0);
        rd_chk(`TERM_OVERRIDE_OFFS, 32'h0000_0000, 2'h0);
        rd_chk(`LATENCY_OFFS, 32'h0000_1806, 2'h0);
        rd_chk(`STATUS_OFFS, 32'h0000_0001, 2'h0);
        rd_chk(12'h0f0, 32'h0000_0000, 2'h2);
        axi_wr(12'h0f0, 32'h1234_5678, 4'hf);
        check("unmapped_bresp", 2'h2, rsp);
        axi_wr(`STATUS_OFFS, 32'hffff_ffff, 4'hf);
        rd_chk(`STATUS_OFFS, 32'h0000_0001, 2'h0);
        axi_wr(`TERM_CONFIG_OFFS, 32'hffff_ffff, 4'h0);
        rd_chk(`TERM_CONFIG_OFFS, 32'h0000_0000, 2'h0);
        axi_wr(`TERM_CONFIG_OFFS, 32'h0000_00ff, 4'hf);
        rd_chk(`TERM_CONFIG_OFFS, 32'h0000_007f, 2'h0);
        // every ca code
        for (int c = 0; c < 8; c++)
        begin
            rnd = $random(seed);
            ovr = rnd[7:0];
            axi_wr(`TERM_OVERRIDE_OFFS, {24'h00_0000, ovr}, 4'hf);
            axi_wr(`TERM_CONFIG_OFFS, {25'h000_0000, c[2:0], 4'h0}, 4'hf);
            repeat (6) @(posedge clk_i);
            #1;
            check("ca_enables", ca_exp({1'b0, c[2:0], 4'h0}, ovr),
                  {ca_term_en_o, ck_term_en_o, cs_term_en_o});
            if (c > 0 && c < 7)
                check("ca_code", c[2:0], ca_term_code_o);
        end
        // random latencies and spacing
        for (int k = 0; k < 6; k++)
        begin
            rnd  = $random(seed);
            lon  = 8'h02 + {5'h00, rnd[2:0]};
            loff = lon + 8'h04 + {4'h0, rnd[7:4]};
            axi_wr(`LATENCY_OFFS, {16'h0000, loff, lon}, 4'hf);
            axi_wr(`TERM_CONFIG_OFFS, {28'h000_0001, 1'b1, rnd[12:10]}, 4'hf);
            check("dq_code", rnd[12:10], dq_term_code_o);
            n0 = n_on;
            i_host.send_write(int'(rnd[9:8]));
            repeat (loff + 8) @(posedge clk_i);
            #1;
            check("dq_rises", n0 + 1, n_on);
            check("on_delay", 1, on_at - col2_at >= lon + 1 && on_at - col2_at <= lon + 4);
            check("window_len", loff - lon, off_at - on_at);
            check("hiz_after", 1'b1, dq_hiz_o);
        end
        // silent writes
        for (int m = 0; m < 4; m++)
        begin
            axi_wr(`TERM_CONFIG_OFFS, (m == 0) ? 32'h0000_0007 : 32'h0000_000f, 4'hf);
            i_host.set_power(m == 1 || m == 3, m >= 2);
            n0 = n_on;
            i_host.send_write(m);
            repeat (40) @(posedge clk_i);
            check("dq_silent", n0, n_on);
            i_host.set_power(1'b0, 1'b0);
        end
        // power-down mid window
        axi_wr(`LATENCY_OFFS, 32'h0000_1e02, 4'hf);
        i_host.send_write(0);
        repeat (6) @(posedge clk_i);
        #1;
        check("dq_open", 1'b1, dq_term_en_o);
        i_host.set_power(1'b1, 1'b0);
        repeat (4) @(posedge clk_i);
        #1;
        check("dq_cut", 1'b0, dq_term_en_o);
        i_host.set_power(1'b0, 1'b0);
        repeat (40) @(posedge clk_i);
        give_verdict();
    end
endmodule // dram_odt_control_tb
